//--- hw/option_byte_config_decoder.sv
// Option byte programming, reset-time latching and decoding into device configuration.
`timescale 1ns/1ps
`include "option_byte_regs.svh"

// Summary of operation
// R1: Halt entry with active watchdog resets when the halt watchdog bit is one.
// R2: Watchdog select zero means hardware watchdog always on; one means software enabled.
// R3: Programmer keeps clock security, voltage detect and reserved bits at default.
// R4: Protect bit zero blocks program memory readout and flash writes.
// R5: Erasing option bytes under protection erases all user memory first.
// R6: Option bytes are read and written only in programming mode.
// R7: Erased bytes read all ones; shipped parts run from internal RC.
// R8: Package bit one selects 44-pin, zero selects 32-pin variants.
// R9: Unbonded pads leave reset as pulled-up inputs, eight pads per port.
// R10: Reset cycle bit zero gives 4096 cycles, one gives 256 cycles.
// R11: Oscillator type 00 resonator, 01 reserved, 10 internal RC, 11 external.
// R12: Programmer never combines external clock with the enabled clock doubler.
// R13: Range bits set resonator drive for resonators, else operating range.
// R14: Range codes 000 1-2, 001 2-4, 010 4-8, 011 8-16 MHz.
// R15: Doubler enabled by zero, only in 2-4 MHz range, never with RC.
// R16: Both bytes are latched during reset and held until next reset.
module option_byte_config_decoder (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic por_n_in,
  input wire logic prog_mode_in,
  input wire logic prog_write_in,
  input wire logic prog_erase_in,
  input wire logic prog_sel_in,
  input wire logic [7:0] prog_wdata_in,
  input wire logic user_mem_erase_done_in,
  input wire logic halt_entry_in,
  input wire logic halt_exit_in,
  input wire logic sw_watchdog_enable_in,
  output logic [7:0] prog_rdata_out,
  output logic prog_busy_out,
  output logic user_mem_erase_req_out,
  output logic cpu_reset_hold_out,
  output logic halt_reset_request_out,
  output logic watchdog_always_on_out,
  output logic watchdog_active_out,
  output logic readout_protect_out,
  output logic flash_write_block_out,
  output logic package_select_out,
  output logic unbonded_pad_pullup_out,
  output logic reset_cycle_select_out,
  output logic [1:0] oscillator_type_out,
  output logic osc_resonator_out,
  output logic osc_rc_out,
  output logic osc_external_out,
  output logic osc_reserved_out,
  output logic [2:0] resonator_drive_out,
  output logic [2:0] operating_range_out,
  output logic pll_enable_out,
  output logic config_error_out
);

  // Tells whether a byte 1 image selects the given oscillator type.
  function automatic logic osc_is(input logic [7:0] b1, input option_byte_pkg::osc_type_e t);
    osc_is = (b1[`OB1_OSC_TYPE_MSB:`OB1_OSC_TYPE_LSB] == t);
  endfunction : osc_is

  // ========================================================================
  // Pin synchronisers for the programming tool side
  // ========================================================================
  logic [12:0] sync1;
  logic [12:0] sync2;
  logic write_d;
  logic erase_d;
  wire [12:0] pin_vec = {prog_mode_in, prog_write_in, prog_erase_in, prog_sel_in,
                         user_mem_erase_done_in, prog_wdata_in};

  // Two flops before any logic reads a tool pin.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1 <= 13'h0000;
      sync2 <= 13'h0000;
      write_d <= 1'b0;
      erase_d <= 1'b0;
    end else begin
      sync1 <= pin_vec;
      sync2 <= sync1;
      write_d <= sync2[11];
      erase_d <= sync2[10];
    end
  end

  wire mode_s = sync2[12];
  wire sel_s = sync2[9];
  wire done_s = sync2[8];
  wire [7:0] wdata_s = sync2[7:0];
  wire write_edge = sync2[11] && !write_d;
  wire erase_edge = sync2[10] && !erase_d;

  // ========================================================================
  // Option byte store and programming sequence
  // ========================================================================
  option_byte_pkg::prog_state_e prog_state;
  option_byte_pkg::prog_state_e next_prog_state;
  logic [7:0] byte0;
  logic [7:0] byte1;

  // Live protection as currently stored, used to order an erase.
  wire stored_protect = !byte0[`OB0_PROTECT_BIT];
  wire prog_idle = (prog_state == option_byte_pkg::PG_IDLE);
  wire store_wr_en = mode_s && prog_idle && write_edge; // [R6]
  wire opt_erase_en = (prog_state == option_byte_pkg::PG_OPT_ERASE);

  // Erase under protection first wipes user memory, then the option bytes.
  always_comb begin
    next_prog_state = prog_state;
    case (prog_state)
      option_byte_pkg::PG_IDLE: begin
        if (mode_s && erase_edge) begin // [R6]
          next_prog_state = stored_protect ? option_byte_pkg::PG_MEM_ERASE // [R5]
                                           : option_byte_pkg::PG_OPT_ERASE;
        end
      end
      option_byte_pkg::PG_MEM_ERASE: begin
        if (done_s) begin // [R5]
          next_prog_state = option_byte_pkg::PG_OPT_ERASE;
        end
      end
      option_byte_pkg::PG_OPT_ERASE: begin
        next_prog_state = option_byte_pkg::PG_IDLE;
      end
      default: begin
        next_prog_state = option_byte_pkg::PG_IDLE;
      end
    endcase
  end

  // Programming state, read-back and erase request.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prog_state <= option_byte_pkg::PG_IDLE;
      prog_rdata_out <= 8'h00;
      prog_busy_out <= 1'b0;
      user_mem_erase_req_out <= 1'b0;
    end else begin
      prog_state <= next_prog_state;
      prog_rdata_out <= mode_s ? (sel_s ? byte1 : byte0) : 8'h00; // [R6]
      prog_busy_out <= (next_prog_state != option_byte_pkg::PG_IDLE);
      user_mem_erase_req_out <= (next_prog_state == option_byte_pkg::PG_MEM_ERASE); // [R5]
    end
  end

  // Erase leaves both bytes all ones.
  option_byte_store u_store ( // [R7]
    .clk_in(clk_in),
    .por_n_in(por_n_in),
    .wr_en_in(store_wr_en),
    .erase_in(opt_erase_en),
    .sel_in(sel_s),
    .wdata_in(wdata_s),
    .byte0_out(byte0),
    .byte1_out(byte1)
  );

  // ========================================================================
  // Reset phase, latching and halt handling
  // ========================================================================
  option_byte_pkg::phase_e phase;
  option_byte_pkg::phase_e next_phase;
  logic [7:0] cfg0;
  logic [7:0] cfg1;
  logic cnt_done;

  wire cnt_start = (phase == option_byte_pkg::PH_LOAD) ||
                   ((phase == option_byte_pkg::PH_HALT) && halt_exit_in);
  wire rst_long = !((phase == option_byte_pkg::PH_LOAD) ? byte1[`OB1_RST_CYC_BIT]
                                                         : cfg1[`OB1_RST_CYC_BIT]);
  wire wdg_active = !cfg0[`OB0_WDG_SEL_BIT] || sw_watchdog_enable_in; // [R2]
  wire in_run = (phase == option_byte_pkg::PH_RUN);
  wire halt_reset = in_run && halt_entry_in && wdg_active && cfg0[`OB0_HALT_WDG_BIT]; // [R1]

  reset_phase_counter u_counter ( // [R10]
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .start_in(cnt_start),
    .long_in(rst_long),
    .done_out(cnt_done)
  );

  // Load, count, run, and halt until woken or reset.
  always_comb begin
    next_phase = phase;
    case (phase)
      option_byte_pkg::PH_LOAD: next_phase = option_byte_pkg::PH_COUNT;
      option_byte_pkg::PH_COUNT: begin
        if (cnt_done) begin
          next_phase = option_byte_pkg::PH_RUN;
        end
      end
      option_byte_pkg::PH_RUN: begin
        if (halt_entry_in && !halt_reset) begin
          next_phase = option_byte_pkg::PH_HALT;
        end
      end
      option_byte_pkg::PH_HALT: begin
        if (halt_exit_in) begin
          next_phase = option_byte_pkg::PH_COUNT; // [R10]
        end
      end
      default: next_phase = option_byte_pkg::PH_LOAD;
    endcase
  end

  // Bytes are captured once after reset release and held until the next reset.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase <= option_byte_pkg::PH_LOAD;
      cfg0 <= `OB0_DEFAULT;
      cfg1 <= `OB1_DEFAULT;
    end else begin
      phase <= next_phase;
      if (phase == option_byte_pkg::PH_LOAD) begin // [R16]
        cfg0 <= byte0;
        cfg1 <= byte1;
      end
    end
  end

  // ========================================================================
  // Decoded configuration outputs
  // ========================================================================
  wire [2:0] range = cfg1[`OB1_RANGE_MSB:`OB1_RANGE_LSB];
  wire is_res = osc_is(cfg1, option_byte_pkg::OSC_RESONATOR);
  wire is_rc = osc_is(cfg1, option_byte_pkg::OSC_RC);
  wire is_ext = osc_is(cfg1, option_byte_pkg::OSC_EXTERNAL);
  wire is_rsv = osc_is(cfg1, option_byte_pkg::OSC_RESERVED);
  wire pll_req = !cfg1[`OB1_PLL_OFF_BIT];
  wire pll_ok = (range == `RANGE_2_4MHZ) && !is_rc && !is_ext; // [R15] [R12]
  // Clock security and voltage detect bits are not decoded; they stay at default.
  wire [7:0] pad_mask = cfg1[`OB1_PKG_BIT] ? 8'h00 : {`PADS_PER_PORT{1'b1}}; // [R9]

  // Every output here is registered, from the latched bytes, the next phase and the halt and watchdog inputs.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cpu_reset_hold_out <= 1'b1;
      halt_reset_request_out <= 1'b0;
      watchdog_always_on_out <= 1'b0;
      watchdog_active_out <= 1'b0;
      readout_protect_out <= 1'b0;
      flash_write_block_out <= 1'b0;
      package_select_out <= 1'b0;
      unbonded_pad_pullup_out <= 1'b1;
      reset_cycle_select_out <= 1'b0;
      oscillator_type_out <= 2'h0;
      osc_resonator_out <= 1'b0;
      osc_rc_out <= 1'b0;
      osc_external_out <= 1'b0;
      osc_reserved_out <= 1'b0;
      resonator_drive_out <= 3'h0;
      operating_range_out <= 3'h0;
      pll_enable_out <= 1'b0;
      config_error_out <= 1'b0;
    end else begin
      cpu_reset_hold_out <= (next_phase != option_byte_pkg::PH_RUN);
      halt_reset_request_out <= halt_reset; // [R1]
      watchdog_always_on_out <= !cfg0[`OB0_WDG_SEL_BIT]; // [R2]
      watchdog_active_out <= wdg_active;
      readout_protect_out <= !cfg0[`OB0_PROTECT_BIT]; // [R4]
      flash_write_block_out <= !cfg0[`OB0_PROTECT_BIT]; // [R4]
      package_select_out <= cfg1[`OB1_PKG_BIT]; // [R8]
      unbonded_pad_pullup_out <= |pad_mask; // [R9]
      reset_cycle_select_out <= cfg1[`OB1_RST_CYC_BIT];
      oscillator_type_out <= cfg1[`OB1_OSC_TYPE_MSB:`OB1_OSC_TYPE_LSB]; // [R11]
      osc_resonator_out <= is_res; // [R11]
      osc_rc_out <= is_rc;
      osc_external_out <= is_ext;
      osc_reserved_out <= is_rsv;
      resonator_drive_out <= is_res ? range : 3'h0; // [R13] [R14]
      operating_range_out <= is_res ? 3'h0 : range; // [R13]
      pll_enable_out <= pll_req && pll_ok; // [R15]
      config_error_out <= (pll_req && !pll_ok) || is_rsv || (range > `RANGE_8_16MHZ);
    end
  end

  // ========================================================================
  // Assertions
  // ========================================================================
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // Cycles spent counting in the current reset or halt-exit phase.
  logic [12:0] phase_cycles;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_cycles <= 13'h0000;
    end else begin
      phase_cycles <= (phase == option_byte_pkg::PH_COUNT) ? phase_cycles + 13'h0001 : 13'h0000;
    end
  end

  wire [2:0] oscillator_range_out_chk = resonator_drive_out | operating_range_out;

  AST_HALT_RESET: assert property ( // [R1]
    in_run && halt_entry_in && wdg_active && cfg0[`OB0_HALT_WDG_BIT] |=> halt_reset_request_out)
    else $error("Halt entry with active watchdog did not request reset");
  AST_HALT_NO_RESET: assert property ( // [R1]
    in_run && halt_entry_in && !cfg0[`OB0_HALT_WDG_BIT]
      |=> !halt_reset_request_out && (phase == option_byte_pkg::PH_HALT))
    else $error("Halt entry reset although halt watchdog bit is zero");
  AST_HW_WATCHDOG: assert property ( // [R2]
    in_run && $stable(phase) |-> watchdog_always_on_out == !cfg0[`OB0_WDG_SEL_BIT])
    else $error("Watchdog type does not follow select bit");
  AST_PROTECT: assert property ( // [R4]
    in_run |-> (readout_protect_out == !cfg0[`OB0_PROTECT_BIT]) &&
               (flash_write_block_out == readout_protect_out))
    else $error("Protection outputs do not follow protect bit");
  AST_ERASE_ORDER: assert property ( // [R5]
    prog_idle && mode_s && erase_edge && stored_protect
      |=> user_mem_erase_req_out && !opt_erase_en)
    else $error("Option bytes erased before user memory under protection");
  AST_PROG_MODE_ONLY: assert property ( // [R6]
    !mode_s |=> (prog_rdata_out == 8'h00) && !$past(store_wr_en))
    else $error("Option bytes accessed outside programming mode");
  AST_ERASE_ONES: assert property ( // [R7]
    opt_erase_en |=> (byte0 == `OB_ERASED) && (byte1 == `OB_ERASED))
    else $error("Erase did not leave all ones");
  AST_PACKAGE: assert property ( // [R8]
    in_run && $past(in_run) |-> package_select_out == cfg1[`OB1_PKG_BIT])
    else $error("Package select does not follow its bit");
  AST_RESET_LENGTH: assert property ( // [R10]
    (phase == option_byte_pkg::PH_COUNT) && cnt_done |->
      phase_cycles == (cfg1[`OB1_RST_CYC_BIT] ? (`RST_CYCLES_SHORT - 13'h0001)
                                              : (`RST_CYCLES_LONG - 13'h0001)))
    else $error("Reset phase length wrong");
  AST_OSC_RC: assert property ( // [R11]
    in_run && $past(in_run) |-> osc_rc_out == (cfg1[5:4] == 2'b10))
    else $error("Internal RC select wrong");
  AST_RANGE_ROUTE: assert property ( // [R13]
    in_run && $past(in_run) && is_res |-> (resonator_drive_out == range) &&
                                          (operating_range_out == 3'h0))
    else $error("Range bits not routed to resonator drive");
  AST_PLL_LEGAL: assert property ( // [R15]
    pll_enable_out |-> (oscillator_range_out_chk == `RANGE_2_4MHZ) && !osc_rc_out &&
                       !osc_external_out)
    else $error("Doubler enabled outside its legal setting");
  AST_CFG_HELD: assert property ( // [R16]
    (phase != option_byte_pkg::PH_LOAD) && ($past(phase) != option_byte_pkg::PH_LOAD)
      |-> $stable(cfg0) && $stable(cfg1))
    else $error("Latched configuration changed before reset");

  COV_RESET_DONE: cover property (phase == option_byte_pkg::PH_COUNT ##1 in_run);
  COV_PROTECTED_ERASE: cover property (user_mem_erase_req_out ##[1:20] opt_erase_en);
  COV_HALT_WAKE: cover property ((phase == option_byte_pkg::PH_HALT) ##1
                                 (phase == option_byte_pkg::PH_COUNT));

endmodule : option_byte_config_decoder

//--- hw/option_byte_pkg.sv
// Types shared by the option byte configuration decoder.
package option_byte_pkg;

  // ========================================================================
  // Oscillator type codes
  // ========================================================================
  typedef enum logic [1:0] {
    OSC_RESONATOR = 2'b00,
    OSC_RESERVED = 2'b01,
    OSC_RC = 2'b10,
    OSC_EXTERNAL = 2'b11
  } osc_type_e;

  // ========================================================================
  // Core reset phase and programming sequence states
  // ========================================================================
  typedef enum logic [1:0] {
    PH_LOAD = 2'b00,
    PH_COUNT = 2'b01,
    PH_RUN = 2'b10,
    PH_HALT = 2'b11
  } phase_e;

  typedef enum logic [1:0] {
    PG_IDLE = 2'b00,
    PG_MEM_ERASE = 2'b01,
    PG_OPT_ERASE = 2'b10
  } prog_state_e;

endpackage : option_byte_pkg

//--- hw/option_byte_regs.svh
// Bit positions, shipped contents and reset-phase counts of the two static option bytes.
`ifndef OPTION_BYTE_REGS_SVH
`define OPTION_BYTE_REGS_SVH

// ==========================================================================
// Byte selection and shipped contents
// ==========================================================================
`define OB_SEL_BYTE0 1'h0
`define OB_SEL_BYTE1 1'h1
`define OB_ERASED 8'hFF
`define OB0_DEFAULT 8'hFF
`define OB1_DEFAULT 8'hEF

// ==========================================================================
// Option byte 0 fields
// ==========================================================================
`define OB0_HALT_WDG_BIT 7
`define OB0_WDG_SEL_BIT 6
`define OB0_CLK_SEC_BIT 5
`define OB0_VDET_MSB 4
`define OB0_VDET_LSB 3
`define OB0_RSV_MSB 2
`define OB0_RSV_LSB 1
`define OB0_PROTECT_BIT 0

// ==========================================================================
// Option byte 1 fields
// ==========================================================================
`define OB1_PKG_BIT 7
`define OB1_RST_CYC_BIT 6
`define OB1_OSC_TYPE_MSB 5
`define OB1_OSC_TYPE_LSB 4
`define OB1_RANGE_MSB 3
`define OB1_RANGE_LSB 1
`define OB1_PLL_OFF_BIT 0

// ==========================================================================
// Range codes, pad count and reset-phase lengths in CPU cycles
// ==========================================================================
`define RANGE_1_2MHZ 3'h0
`define RANGE_2_4MHZ 3'h1
`define RANGE_4_8MHZ 3'h2
`define RANGE_8_16MHZ 3'h3
`define PADS_PER_PORT 8
`define RST_CYCLES_LONG 13'h1000
`define RST_CYCLES_SHORT 13'h0100

`endif

//--- hw/option_byte_store.sv
// Non-volatile store of the two option bytes, cleared to shipped contents at power-on.
`timescale 1ns/1ps
`include "option_byte_regs.svh"

module option_byte_store (
  input wire logic clk_in,
  input wire logic por_n_in,
  input wire logic wr_en_in,
  input wire logic erase_in,
  input wire logic sel_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] byte0_out,
  output logic [7:0] byte1_out
);

  logic [7:0] mem [0:1];

  // ========================================================================
  // Storage cells
  // ========================================================================
  // Each byte is written when selected and both go to all ones on erase.
  generate
    for (genvar i = 0; i < 2; i++) begin : g_cell
      always_ff @(posedge clk_in or negedge por_n_in) begin
        if (!por_n_in) begin
          mem[i] <= (i == 0) ? `OB0_DEFAULT : `OB1_DEFAULT;
        end else if (erase_in) begin
          mem[i] <= `OB_ERASED;
        end else if (wr_en_in && (sel_in == 1'(i))) begin
          mem[i] <= wdata_in;
        end
      end
    end
  endgenerate

  assign byte0_out = mem[0];
  assign byte1_out = mem[1];

endmodule : option_byte_store

//--- hw/reset_phase_counter.sv
// Down counter that times the reset phase and the exit from halt.
`timescale 1ns/1ps
`include "option_byte_regs.svh"

module reset_phase_counter (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic long_in,
  output logic done_out
);

  logic [12:0] count;

  // ========================================================================
  // Counter
  // ========================================================================
  // A start loads the full length; done marks the last counted cycle.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= 13'h0000;
    end else if (start_in) begin
      count <= long_in ? `RST_CYCLES_LONG : `RST_CYCLES_SHORT;
    end else if (count != 13'h0000) begin
      count <= count - 13'h0001;
    end
  end

  assign done_out = (count == 13'h0001);

endmodule : reset_phase_counter

//--- verification/prog_tool_model.sv
// Behavioural programming tool that drives the option byte pins of the decoder.
`timescale 1ns/1ps

module prog_tool_model (
  input wire logic clk_in,
  input wire logic user_mem_erase_req_in,
  input wire logic [7:0] prog_rdata_in,
  output logic prog_mode_out,
  output logic prog_write_out,
  output logic prog_erase_out,
  output logic prog_sel_out,
  output logic [7:0] prog_wdata_out,
  output logic erase_done_out
);
  // ==========================================================================
  // Programmed image and pin drivers
  // ==========================================================================
  logic [7:0] ob0 = 8'hFF;
  logic [7:0] ob1 = 8'hEF;
  int done_dly = 3;

  // All tool pins idle low at time zero.
  initial begin
    prog_mode_out = 1'b0;
    prog_write_out = 1'b0;
    prog_erase_out = 1'b0;
    prog_sel_out = 1'b0;
    prog_wdata_out = 8'h00;
    erase_done_out = 1'b0;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
  endtask : step

  // Writes one byte; reserved bits and illegal doubler requests are made legal first.
  task automatic wr(input logic sel, input logic [7:0] d, input logic mode);
    logic [7:0] v;
    v = d;
    if (!sel) v[5:1] = 5'h1F;
    if (sel && (v[5] || v[3:1] != 3'h1)) v[0] = 1'b1;
    prog_mode_out <= mode;
    prog_sel_out <= sel;
    prog_wdata_out <= v;
    step(4);
    prog_write_out <= 1'b1;
    step(4);
    prog_write_out <= 1'b0;
    prog_wdata_out <= ~v;
    step(4);
    prog_mode_out <= 1'b0;
    step(1);
    if (mode && sel) ob1 = v;
    if (mode && !sel) ob0 = v;
  endtask : wr

  // Reads one stored byte back while in programming mode.
  task automatic rd(input logic sel, output logic [7:0] q);
    prog_mode_out <= 1'b1;
    prog_sel_out <= sel;
    step(6);
    q = prog_rdata_in;
    prog_mode_out <= 1'b0;
    step(1);
  endtask : rd

  // Pulses the erase strobe; programming mode stays up for the erase sequence.
  task automatic er();
    prog_mode_out <= 1'b1;
    step(4);
    prog_erase_out <= 1'b1;
    step(4);
    prog_erase_out <= 1'b0;
    ob0 = 8'hFF;
    ob1 = 8'hFF;
  endtask : er

  // Answers a user memory erase request after a delay and drops done once it is gone.
  always @(posedge clk_in) begin
    if (user_mem_erase_req_in && !erase_done_out) begin
      step(done_dly);
      erase_done_out <= 1'b1;
    end else if (!user_mem_erase_req_in) begin
      erase_done_out <= 1'b0;
    end
  end
endmodule : prog_tool_model

//--- verification/tb.sv
// Self-checking bench for the option byte configuration decoder.
`timescale 1ns/1ps

module tb;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic clk_in, rst_n_in, por_n_in, halt_entry_in, halt_exit_in, sw_watchdog_enable_in;
  logic prog_mode_in, prog_write_in, prog_erase_in, prog_sel_in, user_mem_erase_done_in;
  logic [7:0] prog_wdata_in, prog_rdata_out;
  logic prog_busy_out, user_mem_erase_req_out, cpu_reset_hold_out, halt_reset_request_out;
  logic watchdog_always_on_out, watchdog_active_out, readout_protect_out;
  logic flash_write_block_out, package_select_out, unbonded_pad_pullup_out, pll_enable_out;
  logic reset_cycle_select_out, osc_resonator_out, osc_rc_out, osc_external_out;
  logic osc_reserved_out, config_error_out;
  logic [1:0] oscillator_type_out;
  logic [2:0] resonator_drive_out, operating_range_out;
  logic seen;
  int bad_count = 0;
  int n_checks = 0;
  int seed = 32'hDC2F;

  option_byte_config_decoder u_dut (.clk_in, .rst_n_in, .por_n_in, .prog_mode_in,
    .prog_write_in, .prog_erase_in, .prog_sel_in, .prog_wdata_in, .user_mem_erase_done_in,
    .halt_entry_in, .halt_exit_in, .sw_watchdog_enable_in, .prog_rdata_out, .prog_busy_out,
    .user_mem_erase_req_out, .cpu_reset_hold_out, .halt_reset_request_out,
    .watchdog_always_on_out, .watchdog_active_out, .readout_protect_out,
    .flash_write_block_out, .package_select_out, .unbonded_pad_pullup_out,
    .reset_cycle_select_out, .oscillator_type_out, .osc_resonator_out, .osc_rc_out,
    .osc_external_out, .osc_reserved_out, .resonator_drive_out, .operating_range_out,
    .pll_enable_out, .config_error_out);

  prog_tool_model u_tool (.clk_in, .user_mem_erase_req_in(user_mem_erase_req_out),
    .prog_rdata_in(prog_rdata_out), .prog_mode_out(prog_mode_in),
    .prog_write_out(prog_write_in), .prog_erase_out(prog_erase_in),
    .prog_sel_out(prog_sel_in), .prog_wdata_out(prog_wdata_in),
    .erase_done_out(user_mem_erase_done_in));

  // The 50 MHz clock.
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // Notes whether a user memory erase was requested.
  always @(posedge clk_in) begin
    if (user_mem_erase_req_out === 1'b1) seen <= 1'b1;
  end

  // ==========================================================================
  // Expectations, comparison and closing report
  // ==========================================================================
  function automatic logic [18:0] exp_cfg(input logic [7:0] b0, input logic [7:0] b1);
    logic [1:0] t;
    logic [2:0] r;
    t = b1[5:4];
    r = b1[3:1];
    return {~b0[6], ~b0[0], ~b0[0], b1[7], ~b1[7], b1[6], t, (t == 2'h0) ? r : 3'h0,
      (t != 2'h0) ? r : 3'h0, ~b1[0] & (r == 3'h1) & ~t[1], t == 2'h2, t == 2'h3,
      t == 2'h0, t == 2'h1};
  endfunction : exp_cfg

  wire [18:0] got = {watchdog_always_on_out, readout_protect_out, flash_write_block_out,
    package_select_out, unbonded_pad_pullup_out, reset_cycle_select_out,
    oscillator_type_out, resonator_drive_out, operating_range_out, pll_enable_out,
    osc_rc_out, osc_external_out, osc_resonator_out, osc_reserved_out};

  task automatic chk(input logic [23:0] seen_v, input logic [23:0] exp_v, input string what);
    n_checks++;
    if (seen_v !== exp_v) begin
      bad_count++;
      $display("FAIL %0t %s got %h exp %h", $time, what, seen_v, exp_v);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  // Counts the cycles until the core leaves the reset phase, bounded.
  task automatic wait_run(input int n);
    int c;
    c = 0;
    while (cpu_reset_hold_out === 1'b1 && c < 6000) begin
      @(posedge clk_in);
      c++;
    end
    chk(19'(c >= n && c <= n + 8), 19'h1, "phase length");
    if (c >= 6000) wrap_up();
  endtask : wait_run

  task automatic do_reset(input logic [7:0] b1);
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    wait_run(b1[6] ? 256 : 4096);
  endtask : do_reset

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    int c;
    logic [31:0] r;
    logic [7:0] b0, b1, q0, q1;
    logic [18:0] e;
    logic h;
    {rst_n_in, por_n_in, halt_entry_in, halt_exit_in, sw_watchdog_enable_in} = 5'h00;
    seen = 1'b0;
    repeat (4) @(posedge clk_in);
    {rst_n_in, por_n_in} <= 2'h3;
    @(posedge clk_in);
    wait_run(256);
    u_tool.rd(1'b0, q0);
    u_tool.rd(1'b1, q1);
    chk(24'(config_error_out), 24'h1, "config error");
    chk({3'h0, q0, q1}, {3'h0, 16'hFFEF}, "shipped");
    chk(got, exp_cfg(8'hFF, 8'hEF), "shipped decode");
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      u_tool.wr(1'b0, {r[15:14], 5'h1F, r[8]}, 1'b1);
      u_tool.wr(1'b1, {r[7], i != 0, 2'(i), i == 0 ? 4'h2 : r[3:0]}, 1'b1);
      u_tool.wr(1'b1, 8'h5A, 1'b0);
      b0 = u_tool.ob0;
      b1 = u_tool.ob1;
      u_tool.rd(1'b0, q0);
      u_tool.rd(1'b1, q1);
      repeat (4) @(posedge clk_in);
      chk({q0, q1, prog_rdata_out}, {b0, b1, 8'h00}, "readback");
      sw_watchdog_enable_in <= r[20];
      do_reset(b1);
      e = exp_cfg(b0, b1);
      chk(got, e, "decode");
      u_tool.wr(1'b0, ~b0, 1'b1);
      chk(got, e, "held");
      h = b0[7] & (~b0[6] | r[20]);
      @(posedge clk_in);
      halt_entry_in <= 1'b1;
      @(posedge clk_in);
      halt_entry_in <= 1'b0;
      #1 chk({watchdog_active_out, halt_reset_request_out, cpu_reset_hold_out},
        {~b0[6] | r[20], h, ~h}, "halt");
      if (!h) begin
        @(posedge clk_in);
        halt_exit_in <= 1'b1;
        @(posedge clk_in);
        halt_exit_in <= 1'b0;
        wait_run(b1[6] ? 256 : 4096);
      end
    end
    for (int p = 1; p >= 0; p--) begin
      u_tool.wr(1'b0, {7'h7F, p == 0}, 1'b1);
      seen = 1'b0;
      u_tool.er();
      c = 0;
      while (prog_busy_out !== 1'b0 && c < 200) begin
        @(posedge clk_in);
        c++;
      end
      if (c >= 200) begin
        chk(19'h1, 19'h0, "erase hang");
        wrap_up();
      end
      u_tool.rd(1'b0, q0);
      u_tool.rd(1'b1, q1);
      chk({seen, q0, q1}, {p == 1, 16'hFFFF}, "erase");
    end
    wrap_up();
  end
endmodule : tb
